// [comparator_control_map.vh]
// register map, field positions and reset values of the comparator control block
// Overview of operation
// - standby_run set keeps comparator running in standby; clear halts it
// - in standby with clock stopped, event flag and status stay frozen
// - pad_drive_on routes the final comparator output to the pad
// - two-bit power profile to analog core; code 0 fastest, most current
// - hysteresis_select bits 2:1 to analog core: none, small, medium, large
// - enable bit 0 of main control turns comparator on or off
// - invert bit 7 of input select flips output for pin, event, interrupt
// - output_preset defines output level until the comparator is ready
// - plus_input_select bits 5:3 picks pin 0, 3 or 4; others none
// - minus_input_select bits 2:0 picks pin 0, 2, 3 or divider threshold
// - eight-bit threshold_code, reset 0xff, drives the internal divider
// - irq_edge_select bits 5:4: 0 any, 2 falling, 3 rising, 1 reserved
// - compare_irq_enable bit 0 raises interrupt request while flag is set
// - compare_level_view shows output level, three synchronizer cycles late
// - matching output transition sets the compare_event_flag
// - writing 1 clears the event flag, writing 0 leaves it
// - interrupt request stays asserted until the flag is cleared
// - raw result high when plus exceeds minus; xor with invert bit
// - power-down disables comparator and pad; idle keeps normal operation
`ifndef COMPARATOR_CONTROL_MAP_VH
`define COMPARATOR_CONTROL_MAP_VH

// register indices; byte address is four times the index
`define REG_MAIN_CONTROL   3'h0
`define REG_INPUT_SELECT   3'h2
`define REG_THRESHOLD      3'h5
`define REG_IRQ_CONTROL    3'h6
`define REG_STATUS         3'h7

// reset values
`define RST_MAIN_CONTROL   8'h00
`define RST_INPUT_SELECT   8'h00
`define RST_THRESHOLD      8'hff
`define RST_IRQ_CONTROL    8'h00

// writable bit masks
`define MASK_MAIN_CONTROL  8'hdf
`define MASK_IRQ_CONTROL   8'h31

// main control fields
`define BIT_ENABLE         0
`define BIT_PAD_DRIVE      6
`define BIT_STANDBY_RUN    7
// input select fields
`define BIT_INVERT         7
`define BIT_PRESET         6
// irq control fields
`define BIT_IRQ_ENABLE     0
// status fields
`define BIT_EVENT_FLAG     0
`define BIT_LEVEL_VIEW     4

// edge select codes
`define EDGE_ANY           2'h0
`define EDGE_FALL          2'h2
`define EDGE_RISE          2'h3

// plus input codes
`define PLUS_PIN_ZERO      3'h0
`define PLUS_PIN_THREE     3'h3
`define PLUS_PIN_FOUR      3'h4
// minus input codes
`define MINUS_PIN_ZERO     3'h0
`define MINUS_PIN_TWO      3'h2
`define MINUS_PIN_THREE    3'h3
`define MINUS_DIVIDER      3'h4

// sleep mode codes
`define SLEEP_ACTIVE       2'h0
`define SLEEP_IDLE         2'h1
`define SLEEP_STANDBY      2'h2
`define SLEEP_POWER_DOWN   2'h3

`endif

// [comparator_control_regs.v]
// comparator control registers, output conditioning and event flag
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "comparator_control_map.vh"

module comparator_control_regs #(
  parameter READY_CYCLES = 16
) (
  // clock and reset
  input  wire        ref_clk,
  input  wire        reset_n,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [4:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // sleep state of the system
  input  wire [1:0]  sleep_mode,
  // analog core
  input  wire        raw_compare,
  output reg         core_on,
  output reg  [1:0]  power_profile,
  output reg  [1:0]  hysteresis_select,
  output reg  [2:0]  plus_input_select,
  output reg  [2:0]  minus_input_select,
  output reg  [4:0]  plus_pin_onehot,
  output reg  [3:0]  minus_pin_onehot,
  output reg  [7:0]  threshold_code,
  // conditioned output
  output wire        compare_out,
  output wire        pad_out,
  output wire        pad_out_en,
  output wire        compare_irq
);

  reg  [7:0] main_control;
  reg  [7:0] input_select;
  reg  [7:0] irq_control;
  reg        compare_event_flag;
  reg        sync_first;
  reg        sync_second;
  reg        level_view;
  reg        level_prev;
  reg  [7:0] ready_count;
  reg        core_ready;
  reg  [7:0] rd_data;
  reg        edge_hit;
  wire [2:0] reg_index;
  wire       wr_strobe;
  wire       rd_strobe;
  wire       active;
  wire       clock_running;
  wire       conditioned;
  wire       rise;
  wire       fall;

  // last count of the start-up timer, cut to the counter width on purpose
  localparam [7:0] READY_LAST = READY_CYCLES - 1;

  assign reg_index = wb_adr_i[4:2];
  // single-cycle answer; ack low for a cycle between requests
  assign wr_strobe = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & wb_sel_i[0];
  assign rd_strobe = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_we_i;

  // comparator operation by sleep state
  assign active = main_control[`BIT_ENABLE] &
    (sleep_mode == `SLEEP_ACTIVE || sleep_mode == `SLEEP_IDLE ||
     (sleep_mode == `SLEEP_STANDBY && main_control[`BIT_STANDBY_RUN]));
  // peripheral clock stops in standby and power-down, so flags freeze
  assign clock_running = (sleep_mode == `SLEEP_ACTIVE) ||
                         (sleep_mode == `SLEEP_IDLE);

  // output conditioning: preset until ready, then raw xor invert
  assign conditioned = core_ready ?
    (raw_compare ^ input_select[`BIT_INVERT]) :
    input_select[`BIT_PRESET];
  assign compare_out = conditioned;
  // pad off in power-down regardless of pad enable
  assign pad_out_en  = main_control[`BIT_PAD_DRIVE] &
                       (sleep_mode != `SLEEP_POWER_DOWN);
  assign pad_out     = conditioned & pad_out_en;
  assign compare_irq = irq_control[`BIT_IRQ_ENABLE] &
                       compare_event_flag;

  // edge detection on synchronized samples
  assign rise = level_view & ~level_prev;
  assign fall = ~level_view & level_prev;

  always @* begin
    case (irq_control[5:4])
      `EDGE_ANY:  edge_hit = rise | fall;
      `EDGE_FALL: edge_hit = fall;
      `EDGE_RISE: edge_hit = rise;
      default:    edge_hit = 1'b0;
    endcase
  end

  // register writes; unused bits masked to zero
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      main_control   <= `RST_MAIN_CONTROL;
      input_select   <= `RST_INPUT_SELECT;
      threshold_code <= `RST_THRESHOLD;
      irq_control    <= `RST_IRQ_CONTROL;
    end else if (wr_strobe) begin
      case (reg_index)
        `REG_MAIN_CONTROL:
          main_control <= wb_dat_i[7:0] & `MASK_MAIN_CONTROL;
        `REG_INPUT_SELECT:
          input_select <= wb_dat_i[7:0];
        `REG_THRESHOLD:
          threshold_code <= wb_dat_i[7:0];
        `REG_IRQ_CONTROL:
          irq_control <= wb_dat_i[7:0] & `MASK_IRQ_CONTROL;
        default: ;
      endcase
    end
  end

  // bus answer
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wr_strobe | rd_strobe |
                  (wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i);
      if (rd_strobe)
        wb_dat_o <= {24'h000000, rd_data};
    end
  end

  // read mux; unmapped reads as zero
  always @* begin
    case (reg_index)
      `REG_MAIN_CONTROL: rd_data = main_control;
      `REG_INPUT_SELECT: rd_data = input_select;
      `REG_THRESHOLD:    rd_data = threshold_code;
      `REG_IRQ_CONTROL:  rd_data = irq_control;
      `REG_STATUS:       rd_data = {3'h0, level_view, 3'h0,
                                    compare_event_flag};
      default:           rd_data = 8'h00;
    endcase
  end

  // start-up timer for preset hold; restarts whenever core goes off
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      ready_count <= 8'h00;
      core_ready  <= 1'b0;
    end else if (!active) begin
      ready_count <= 8'h00;
      core_ready  <= 1'b0;
    end else if (!core_ready) begin
      if (ready_count == READY_LAST)
        core_ready <= 1'b1;
      else
        ready_count <= ready_count + 8'h01;
    end
  end

  // three-stage level path; frozen while the clock is stopped
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      sync_first  <= 1'b0;
      sync_second <= 1'b0;
      level_view  <= 1'b0;
      level_prev  <= 1'b0;
    end else if (clock_running) begin
      sync_first  <= conditioned;
      sync_second <= sync_first;
      level_view  <= sync_second;
      level_prev  <= level_view;
    end
  end

  // event flag; set wins over a clear in the same cycle
  always @(posedge ref_clk) begin
    if (!reset_n)
      compare_event_flag <= 1'b0;
    else if (clock_running && edge_hit)
      compare_event_flag <= 1'b1;
    else if (wr_strobe && reg_index == `REG_STATUS &&
             wb_dat_i[`BIT_EVENT_FLAG])
      compare_event_flag <= 1'b0;
  end

  // analog core drive; reserved codes select no pin
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      core_on            <= 1'b0;
      power_profile      <= 2'h0;
      hysteresis_select  <= 2'h0;
      plus_input_select  <= 3'h0;
      minus_input_select <= 3'h0;
      plus_pin_onehot    <= 5'h00;
      minus_pin_onehot   <= 4'h0;
    end else begin
      core_on            <= active;
      power_profile      <= main_control[4:3];
      hysteresis_select  <= main_control[2:1];
      plus_input_select  <= input_select[5:3];
      minus_input_select <= input_select[2:0];
      case (input_select[5:3])
        `PLUS_PIN_ZERO:  plus_pin_onehot <= 5'h01;
        `PLUS_PIN_THREE: plus_pin_onehot <= 5'h08;
        `PLUS_PIN_FOUR:  plus_pin_onehot <= 5'h10;
        default:         plus_pin_onehot <= 5'h00;
      endcase
      case (input_select[2:0])
        `MINUS_PIN_ZERO:  minus_pin_onehot <= 4'h1;
        `MINUS_PIN_TWO:   minus_pin_onehot <= 4'h2;
        `MINUS_PIN_THREE: minus_pin_onehot <= 4'h4;
        `MINUS_DIVIDER:   minus_pin_onehot <= 4'h8;
        default:          minus_pin_onehot <= 4'h0;
      endcase
    end
  end

endmodule

// [comparator_control_monitor.sv]
// concurrent checks on the ports of the comparator control block
`timescale 1ns/1ps

module comparator_control_monitor #(
  parameter READY_CYCLES = 16
) (
  // clock, reset and bus
  input wire        ref_clk,
  input wire        reset_n,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  // sleep and core
  input wire [1:0]  sleep_mode,
  input wire        core_on,
  input wire [2:0]  plus_input_select,
  input wire [2:0]  minus_input_select,
  input wire [4:0]  plus_pin_onehot,
  input wire [3:0]  minus_pin_onehot,
  // conditioned output
  input wire        compare_out,
  input wire        pad_out,
  input wire        pad_out_en,
  input wire        compare_irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // a taken request is answered once, then ack drops
  a_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not a single pulse");
  a_read_upper_zero: assert property (
    wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data set");
  a_pad_gated: assert property (
    pad_out == (compare_out & pad_out_en)) else $error("pad mismatch");
  a_pad_off_pd: assert property (
    sleep_mode == 2'h3 |-> !pad_out_en) else $error("pad on in power-down");
  a_core_off_pd: assert property (
    sleep_mode == 2'h3 |=> !core_on) else $error("core on in power-down");
  // the request only falls after a write was taken
  a_irq_holds: assert property (
    $fell(compare_irq) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i
    && !wb_ack_o)) else $error("irq dropped without a write");
  a_plus_pin_four: assert property (
    plus_input_select == 3'h4 |-> plus_pin_onehot == 5'h10)
    else $error("plus pin four not selected");
  a_plus_reserved: assert property (
    plus_input_select inside {3'h1, 3'h2, 3'h5, 3'h6, 3'h7}
    |-> plus_pin_onehot == 5'h00) else $error("reserved plus selects");
  a_minus_divider: assert property (
    minus_input_select == 3'h4 |-> minus_pin_onehot == 4'h8)
    else $error("divider not selected");

  c_irq: cover property ($rose(compare_irq));
  c_pad: cover property (pad_out_en && pad_out);
  c_pd: cover property (sleep_mode == 2'h3 ##1 !core_on);
endmodule

bind comparator_control_regs comparator_control_monitor #(
  .READY_CYCLES(READY_CYCLES)) mon (.ref_clk(ref_clk), .reset_n(reset_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_mode(sleep_mode),
  .core_on(core_on), .plus_input_select(plus_input_select),
  .minus_input_select(minus_input_select),
  .plus_pin_onehot(plus_pin_onehot), .minus_pin_onehot(minus_pin_onehot),
  .compare_out(compare_out), .pad_out(pad_out), .pad_out_en(pad_out_en),
  .compare_irq(compare_irq));

// [analog_core_model.sv]
// behavioural model of the analog comparator core
`timescale 1ns/1ps

module analog_core_model (
  // clock and control
  input  wire  ref_clk,
  input  wire  core_on,
  // plus above minus, as set by the bench
  input  wire  level,
  output logic raw_compare
);
  logic flip = 1'b0;

  // an idle core gives no steady level to lean on
  always @(posedge ref_clk) flip <= ~flip;
  assign raw_compare = core_on ? level : flip;
endmodule

// [comparator_control_regs_tb.sv]
// self-checking bench for the comparator control block
`timescale 1ns/1ps

module comparator_control_regs_tb;
  logic ref_clk = 1'b0, reset_n, level, raw_compare, core_on;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [4:0] wb_adr_i, plus_pin_onehot;
  logic [3:0] wb_sel_i, minus_pin_onehot;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [1:0] sleep_mode, power_profile, hysteresis_select, m;
  logic [2:0] plus_input_select, minus_input_select;
  logic [7:0] threshold_code;
  logic compare_out, pad_out, pad_out_en, compare_irq, e;
  int n_mismatch = 0, checks = 0, cycles = 0, i;

  comparator_control_regs #(.READY_CYCLES(2)) uut (.ref_clk(ref_clk),
    .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sleep_mode(sleep_mode), .raw_compare(raw_compare), .core_on(core_on),
    .power_profile(power_profile), .hysteresis_select(hysteresis_select),
    .plus_input_select(plus_input_select),
    .minus_input_select(minus_input_select),
    .plus_pin_onehot(plus_pin_onehot), .minus_pin_onehot(minus_pin_onehot),
    .threshold_code(threshold_code), .compare_out(compare_out),
    .pad_out(pad_out), .pad_out_en(pad_out_en), .compare_irq(compare_irq));
  analog_core_model core (.ref_clk(ref_clk), .core_on(core_on),
    .level(level), .raw_compare(raw_compare));

  always #2 ref_clk = ~ref_clk;
  // hang guard, far above the few hundred cycles needed
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task end_of_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task chk(input string n, input [31:0] s, input [31:0] x);
    checks++;
    if (s !== x) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask

  // one classic cycle, entered just after a rising edge
  task bus(input w, input [2:0] a, input [7:0] d);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    wb_adr_i <= {a, 2'b00};
    wb_dat_i <= {24'h0, d};
    @(posedge ref_clk);
    while (wb_ack_o !== 1'b1) @(posedge ref_clk);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    @(posedge ref_clk);
  endtask

  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    {wb_adr_i, wb_dat_i, sleep_mode, level, reset_n} <= 0;
    wb_sel_i <= 4'h1;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (i = 0; i < 8; i++) begin
      bus(0, i, 0);
      chk("reset", q, i == 5 ? 32'hff : 32'h0);
    end
    bus(1, 0, 8'hff);
    bus(0, 0, 0);
    chk("main", q, 32'hdf);
    chk("profile", power_profile, 2'h3);
    chk("hyst", hysteresis_select, 2'h3);
    chk("on", core_on, 1);
    bus(1, 5, 8'h5a);
    chk("thresh", threshold_code, 8'h5a);
    bus(1, 0, 8'h02);
    chk("off", core_on, 0);
    for (i = 0; i < 8; i++) begin
      bus(1, 2, {2'b00, i[2:0], i[2:0]});
      bus(0, 2, 0);
      chk("sel", q, {i[2:0], i[2:0]});
      chk("plus_sel", plus_input_select, i[2:0]);
      chk("minus_sel", minus_input_select, i[2:0]);
      chk("plus", plus_pin_onehot, i == 0 ? 1 : i == 3 ? 8 :
        i == 4 ? 16 : 0);
      chk("minus", minus_pin_onehot, i == 0 ? 1 : i == 2 ? 2 :
        i == 3 ? 4 : i == 4 ? 8 : 0);
    end
    bus(1, 2, 8'h40);
    chk("preset", compare_out, 1);
    bus(1, 0, 8'h41);
    repeat (8) @(posedge ref_clk);
    chk("ready", compare_out, 0);
    bus(1, 2, 8'h80);
    chk("invert", pad_out, 1);
    bus(1, 2, 8'h00);
    repeat (6) @(posedge ref_clk);
    bus(1, 7, 8'h01);
    // every edge mode, each seeing both edges
    for (i = 0; i < 8; i++) begin
      m = i[2:1];
      bus(1, 6, {2'b00, m, 4'h1});
      level <= ~level;
      repeat (6) @(posedge ref_clk);
      e = m == 0 || (m == 3 && level) || (m == 2 && !level);
      chk("irq", compare_irq, e);
      bus(1, 7, 8'h00);
      chk("hold", compare_irq, e);
      bus(0, 7, 0);
      chk("status", q, {level, 3'h0, e});
      bus(1, 7, 8'h01);
      chk("clear", compare_irq, 0);
    end
    sleep_mode <= 2'h3;
    repeat (2) @(posedge ref_clk);
    chk("pd", {core_on, pad_out_en}, 0);
    sleep_mode <= 2'h2;
    repeat (2) @(posedge ref_clk);
    chk("stby", core_on, 0);
    sleep_mode <= 2'h1;
    bus(1, 0, 8'hc1);
    chk("idle", core_on, 1);
    sleep_mode <= 2'h2;
    level <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk("run", core_on, 1);
    chk("frozen", compare_irq, 0);
    end_of_test();
  end
endmodule
